// >>> idp_pkg.sv
// idp_pkg: constants and carrier types for the isa dma priority and address logic
// assumes a 50 MHz core clock and an isa bus clock of about 8.33 MHz
// Function
// [RULE1] bus arbiter rotates among dma, refresh and pci side
// [RULE2] channels 0-3 and 4-7 each use fixed or rotating priority
// [RULE3] software requests are prioritised like hardware request lines
// [RULE4] fixed order: lower group first, then 5, 6, 7
// [RULE5] rotating group puts the serviced channel last in its group
// [RULE6] upper rotation has four slots: 5, 6, 7 and the lower group
// [RULE7] lower channel service also moves the lower slot to the upper bottom
// [RULE8] fast timing channel is preempted by any other requester
// [RULE9] preempted channel drops acknowledge within 32 bus clocks, after its cycle; here it drops at the first cycle end after 32 contended bus clocks
// [RULE10] no preemption for compatible timing or cascade masters
// [RULE11] preempted block channel keeps requesting without its request line
// [RULE12] dma skipped while nmi pending and pci side requests
// [RULE13] guaranteed access mode requests memory and withholds acknowledge until granted
// [RULE14] memory arbiter grants only once main memory is owned
// [RULE15] channel 4 is always cascade; software must not change it
// [RULE16] writing lower address bytes selects compatibility mode, high page zero
// [RULE17] high byte written last selects extended 32-bit counting
// [RULE18] reset and master clear return channels to compatibility mode
// [RULE19] address steps 1, or 2 for 16-bit byte-count channels
// [RULE20] shifted word mode drives bit 0 zero, bits 16:1 from 15:0
// [RULE21] writes load base and current together; autoinit reloads at terminal count
// [RULE22] autoinit channel stays unmasked at terminal count
// [RULE23] compatible-timing request lines delayed eight bus clocks
// [RULE24] master clear clears request, status, rotation and sets masks
// [RULE25] rotation updates at completion of each serviced transfer
package idp_pkg;
  // -----------------------------------------------------------------
  // timing
  // -----------------------------------------------------------------
  localparam int CORE_HZ = 50000000;
  localparam int BCLK_HZ = 8333333;
  localparam int BCLK_DIV = CORE_HZ / BCLK_HZ;
  localparam int PREEMPT_BCLKS = 32;
  localparam int REQ_DLY_BCLKS = 8;
  // -----------------------------------------------------------------
  // encodings and reset values
  // -----------------------------------------------------------------
  localparam logic [2:0] CASCADE_CH = 3'h4;
  localparam logic [2:0] SEL_HPAGE = 3'h3;
  localparam logic [2:0] SEL_CNT0 = 3'h4;
  localparam logic [2:0] SEL_CNT1 = 3'h5;
  localparam logic [1:0] TIM_COMPAT = 2'h0;
  localparam logic [1:0] ARB_DMA = 2'h0;
  localparam logic [1:0] ARB_REF = 2'h1;
  localparam logic [1:0] ARB_PCI = 2'h2;
  localparam logic [1:0] ARB_NONE = 2'h3;
  localparam logic [7:0] MASK_RST = 8'hFF;
  localparam logic [31:0] ADDR_RST = 32'h00000000;
  localparam logic [15:0] CNT_RST = 16'h0000;
  typedef enum logic [1:0] {OWN_NONE, OWN_DMA, OWN_REF, OWN_PCI} idp_owner_t;
  typedef struct packed {
    logic [1:0] timing;
    logic block;
    logic cascade;
    logic decr;
    logic autoinit;
    logic wide16;
    logic shifted;
  } idp_chan_cfg_t;
  typedef struct packed {
    logic en;
    logic [2:0] ch;
    logic [2:0] sel;
    logic [7:0] data;
  } idp_wr_t;
endpackage

// >>> idp_req_cond.sv
// idp_req_cond: pin synchronisers and compatible-timing request delay
// assumes bclk_en is a one-cycle pulse per isa bus clock
`timescale 1ns/1ps
module idp_req_cond (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic bclk_en,
  // pins
  input wire logic [7:0] req_pin,
  input wire logic gnt_n_pin,
  // per channel timing
  input wire logic [7:0] compat,
  // conditioned levels
  output logic [7:0] req_seen,
  output logic gnt_n_seen
);
  logic [8:0] pin_all;
  logic [8:0] q_all;
  assign pin_all = {gnt_n_pin, req_pin};
  // -----------------------------------------------------------------
  // three flop synchronisers, change taken when stages 2 and 3 agree
  // -----------------------------------------------------------------
  for (genvar i = 0; i < 9; i++) begin : g_sync
    logic [2:0] s_r;
    logic [2:0] s_nxt;
    logic q_r;
    logic q_nxt;
    always_comb begin
      s_nxt = {s_r[1:0], pin_all[i]};
      q_nxt = (s_r[1] == s_r[2]) ? s_r[2] : q_r;
    end
    always_ff @(posedge clk or posedge rst) begin
      // the grant pin idles high; its stages reset high so reset shows no false grant
      if (rst) begin
        s_r <= (i == 8) ? 3'h7 : 3'h0;
        q_r <= (i == 8) ? 1'b1 : 1'b0;
      end else begin
        s_r <= s_nxt;
        q_r <= q_nxt;
      end
    end
    assign q_all[i] = q_r;
  end
  assign gnt_n_seen = q_all[8];
  // -----------------------------------------------------------------
  // request delay, keeps old slow slaves from seeing a too-quick ack
  // -----------------------------------------------------------------
  for (genvar i = 0; i < 8; i++) begin : g_dly
    logic [idp_pkg::REQ_DLY_BCLKS-1:0] d_r;
    logic [idp_pkg::REQ_DLY_BCLKS-1:0] d_nxt;
    always_comb begin
      d_nxt = bclk_en ? {d_r[idp_pkg::REQ_DLY_BCLKS-2:0], q_all[i]} : d_r;
    end
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        d_r <= '0;
      end else begin
        d_r <= d_nxt;
      end
    end
    assign req_seen[i] = compat[i] ? d_r[idp_pkg::REQ_DLY_BCLKS-1] : q_all[i]; // [RULE23]
  end
endmodule

// >>> idp_dma_arb.sv
// idp_dma_arb: isa bus arbitration, dma channel priority and address generation
// assumes same-clock pulses for cycle completion and terminal count from the cycle engine
`timescale 1ns/1ps
module idp_dma_arb (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RST,
  // isa pins
  input wire logic [7:0] CHANNEL_REQUEST_LINE,
  input wire logic MAIN_MEMORY_GRANT_N,
  output logic [7:0] CHANNEL_ACKNOWLEDGE_N,
  output logic MAIN_MEMORY_REQUEST_N,
  // other requesters
  input wire logic REFRESH_REQ,
  input wire logic PCI_REQ,
  input wire logic NMI_PENDING,
  // cycle engine
  input wire logic CYCLE_DONE,
  input wire logic TERMINAL_COUNT,
  // configuration
  input wire logic GUARANTEED_ACCESS_MODE,
  input wire logic ROTATE_LOW,
  input wire logic ROTATE_HIGH,
  input idp_pkg::idp_chan_cfg_t [7:0] CHAN_CFG,
  // software commands
  input idp_pkg::idp_wr_t REG_WR,
  input wire logic [7:0] SW_REQ_SET,
  input wire logic [7:0] MASK_CLEAR,
  input wire logic [1:0] MASTER_CLEAR,
  // status
  output idp_pkg::idp_owner_t BUS_OWNER,
  output logic [2:0] ACTIVE_CH,
  output logic [31:0] XFER_ADDR,
  output logic [15:0] XFER_COUNT,
  output logic [7:0] TC_STATUS,
  output logic [7:0] MASK_STATE,
  output logic [7:0] EXT_MODE,
  output logic PREEMPT_PEND
);
  typedef enum {ST_IDLE, ST_MEMWAIT, ST_DMA, ST_OWN} idp_state_t;
  idp_state_t st_r;
  idp_state_t st_nxt;
  logic [2:0] div_r;
  logic [2:0] div_nxt;
  logic bclk_en_r;
  logic bclk_nxt;
  logic [1:0] arb_rot_r;
  logic [1:0] arb_rot_nxt;
  logic [1:0] lo_rot_r;
  logic [1:0] lo_rot_nxt;
  logic [1:0] hi_rot_r;
  logic [1:0] hi_rot_nxt;
  logic [2:0] cur_ch_r;
  logic [2:0] cur_ch_nxt;
  logic [7:0] channel_acknowledge_n_n_r;
  logic [7:0] channel_acknowledge_n_n_nxt;
  logic main_memory_request_n_n_r;
  logic main_memory_request_n_n_nxt;
  idp_pkg::idp_owner_t owner_r;
  idp_pkg::idp_owner_t owner_nxt;
  logic [5:0] pre_cnt_r;
  logic [5:0] pre_cnt_nxt;
  logic pre_exp_r;
  logic pre_exp_nxt;
  logic [7:0] keep_r;
  logic [7:0] keep_nxt;
  logic [7:0] swreq_r;
  logic [7:0] swreq_nxt;
  logic [7:0] mask_r;
  logic [7:0] mask_nxt;
  logic [7:0] tc_r;
  logic [7:0] tc_nxt;
  logic [31:0] base_a_r [8];
  logic [31:0] base_a_nxt [8];
  logic [31:0] cur_a_r [8];
  logic [31:0] cur_a_nxt [8];
  logic [15:0] base_c_r [8];
  logic [15:0] base_c_nxt [8];
  logic [15:0] cur_c_r [8];
  logic [15:0] cur_c_nxt [8];
  logic [7:0] ext_r;
  logic [7:0] ext_nxt;
  logic [31:0] xaddr_r;
  logic [31:0] xaddr_nxt;
  logic [15:0] xcnt_r;
  logic [15:0] xcnt_nxt;
  logic [7:0] hw_req;
  logic [7:0] compat;
  logic [7:0] eff_req;
  logic [7:0] cur_bit;
  logic gnt_s;
  logic cas_cur;
  logic fast_cur;
  logic contend;
  logic dma_ok;
  logic [2:0] win;
  logic [1:0] top;
  logic [2:0] arb_req;
  logic rel;
  logic xfer_done;
  logic ext_cur;
  // -----------------------------------------------------------------
  // functions
  // -----------------------------------------------------------------
  // walks the four upper slots from hr; slot 0 stands for the lower group
  function automatic logic [2:0] pick(input logic [7:0] rq, input logic [1:0] lr,
                                      input logic [1:0] hr);
    logic [2:0] res;
    logic [1:0] s;
    logic [1:0] l;
    res = 3'h0;
    for (int i = 3; i >= 0; i--) begin
      s = hr + 2'(i);
      if (s == 2'h0) begin
        for (int j = 3; j >= 0; j--) begin
          l = lr + 2'(j);
          if (rq[l]) res = {1'b0, l};
        end
      end else if (rq[{1'b1, s}]) begin
        res = {1'b1, s};
      end
    end
    return res;
  endfunction
  function automatic logic [31:0] out_addr(input logic [31:0] a, input logic ext,
                                           input idp_pkg::idp_chan_cfg_t cf);
    logic [31:0] r;
    r = a;
    if (!ext) r[31:24] = 8'h00; // [RULE16]
    if (cf.wide16 && cf.shifted) r = {r[31:17], a[15:0], 1'b0}; // [RULE20]
    return r;
  endfunction
  // 16-bit byte-count channels step by two, all others by one
  function automatic logic [15:0] step16(input idp_pkg::idp_chan_cfg_t cf);
    return (cf.wide16 && !cf.shifted) ? 16'h0002 : 16'h0001;
  endfunction
  // -----------------------------------------------------------------
  // request conditioning
  // -----------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < 8; i++) compat[i] = CHAN_CFG[i].timing == idp_pkg::TIM_COMPAT;
  end
  idp_req_cond u_cond (
    .clk(CORE_CLK),
    .rst(RST),
    .bclk_en(bclk_en_r),
    .req_pin(CHANNEL_REQUEST_LINE),
    .gnt_n_pin(MAIN_MEMORY_GRANT_N),
    .compat(compat),
    .req_seen(hw_req),
    .gnt_n_seen(gnt_s)
  );
  // software and held requests share one path with the pins
  assign eff_req = (hw_req | swreq_r | keep_r) & ~mask_r & ~(8'h01 << idp_pkg::CASCADE_CH); // [RULE3] [RULE15]
  assign cur_bit = 8'h01 << cur_ch_r;
  assign cas_cur = CHAN_CFG[cur_ch_r].cascade;
  assign fast_cur = !compat[cur_ch_r] && !cas_cur; // [RULE10]
  assign contend = REFRESH_REQ || PCI_REQ || |(eff_req & ~cur_bit);
  // a memory grant still seen from the last owner must fall before a new request
  assign dma_ok = |eff_req && !(NMI_PENDING && PCI_REQ) && // [RULE12]
                  !(GUARANTEED_ACCESS_MODE && !gnt_s); // [RULE13]
  assign arb_req = {PCI_REQ, REFRESH_REQ, dma_ok};
  assign win = pick(eff_req, ROTATE_LOW ? lo_rot_r : 2'h0,
                    ROTATE_HIGH ? hi_rot_r : 2'h0); // [RULE2] [RULE4] [RULE6]
  assign xfer_done = st_r == ST_DMA && CYCLE_DONE && !cas_cur;
  assign ext_cur = ext_r[cur_ch_r];
  // -----------------------------------------------------------------
  // bus clock divider and three-way rotation
  // -----------------------------------------------------------------
  always_comb begin
    bclk_nxt = div_r == 3'(idp_pkg::BCLK_DIV - 1);
    div_nxt = bclk_nxt ? 3'h0 : div_r + 3'h1;
    top = idp_pkg::ARB_NONE;
    for (int i = 2; i >= 0; i--) begin
      if (arb_req[(int'(arb_rot_r) + i) % 3]) begin
        top = 2'((int'(arb_rot_r) + i) % 3); // [RULE1]
      end
    end
  end
  // -----------------------------------------------------------------
  // arbitration state machine
  // -----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    arb_rot_nxt = arb_rot_r;
    lo_rot_nxt = lo_rot_r;
    hi_rot_nxt = hi_rot_r;
    cur_ch_nxt = cur_ch_r;
    channel_acknowledge_n_n_nxt = channel_acknowledge_n_n_r;
    main_memory_request_n_n_nxt = main_memory_request_n_n_r;
    owner_nxt = owner_r;
    pre_cnt_nxt = pre_cnt_r;
    pre_exp_nxt = pre_exp_r;
    keep_nxt = keep_r;
    swreq_nxt = swreq_r;
    mask_nxt = mask_r & ~MASK_CLEAR;
    tc_nxt = tc_r;
    rel = 1'b0;
    // clears go first so a same-cycle software request set wins
    for (int g = 0; g < 2; g++) begin
      if (MASTER_CLEAR[g]) begin
        swreq_nxt[4*g +: 4] = 4'h0; // [RULE24]
        tc_nxt[4*g +: 4] = 4'h0;
        keep_nxt[4*g +: 4] = 4'h0;
        mask_nxt[4*g +: 4] = 4'hF;
        if (g == 0) lo_rot_nxt = 2'h0;
        else hi_rot_nxt = 2'h0;
      end
    end
    case (st_r)
      ST_IDLE: begin
        if (top != idp_pkg::ARB_NONE) begin
          arb_rot_nxt = (top == idp_pkg::ARB_PCI) ? 2'h0 : top + 2'h1; // [RULE1]
        end
        if (top == idp_pkg::ARB_DMA) begin
          cur_ch_nxt = win;
          keep_nxt[win] = 1'b0;
          pre_cnt_nxt = 6'h00;
          pre_exp_nxt = 1'b0;
          if (GUARANTEED_ACCESS_MODE) begin
            main_memory_request_n_n_nxt = 1'b0; // [RULE13]
            st_nxt = ST_MEMWAIT;
          end else begin
            channel_acknowledge_n_n_nxt[win] = 1'b0;
            owner_nxt = idp_pkg::OWN_DMA;
            st_nxt = ST_DMA;
          end
        end else if (top == idp_pkg::ARB_REF) begin
          owner_nxt = idp_pkg::OWN_REF;
          st_nxt = ST_OWN;
        end else if (top == idp_pkg::ARB_PCI) begin
          owner_nxt = idp_pkg::OWN_PCI;
          st_nxt = ST_OWN;
        end
      end
      ST_MEMWAIT: begin
        if (MASTER_CLEAR[cur_ch_r[2]]) begin
          rel = 1'b1;
        end else if (!gnt_s) begin
          channel_acknowledge_n_n_nxt[cur_ch_r] = 1'b0; // [RULE13] [RULE14]
          owner_nxt = idp_pkg::OWN_DMA;
          st_nxt = ST_DMA;
        end
      end
      ST_OWN: begin
        if ((owner_r == idp_pkg::OWN_REF && !REFRESH_REQ) ||
            (owner_r == idp_pkg::OWN_PCI && !PCI_REQ)) begin
          owner_nxt = idp_pkg::OWN_NONE;
          st_nxt = ST_IDLE;
        end
      end
      ST_DMA: begin
        if (fast_cur && contend && !pre_exp_r && bclk_en_r) begin
          pre_cnt_nxt = pre_cnt_r + 6'h01; // [RULE8]
          if (pre_cnt_r == 6'(idp_pkg::PREEMPT_BCLKS - 1)) pre_exp_nxt = 1'b1; // [RULE9]
        end
        if (MASTER_CLEAR[cur_ch_r[2]]) begin
          rel = 1'b1;
        end else if (cas_cur) begin
          rel = !eff_req[cur_ch_r];
        end else if (CYCLE_DONE) begin
          if (!cur_ch_r[2] && ROTATE_LOW) lo_rot_nxt = cur_ch_r[1:0] + 2'h1; // [RULE5] [RULE25]
          if (ROTATE_HIGH) begin
            hi_rot_nxt = cur_ch_r[2] ? cur_ch_r[1:0] + 2'h1 : 2'h1; // [RULE6] [RULE7]
          end
          if (TERMINAL_COUNT) begin
            tc_nxt[cur_ch_r] = 1'b1;
            swreq_nxt[cur_ch_r] = 1'b0;
            if (!CHAN_CFG[cur_ch_r].autoinit) mask_nxt[cur_ch_r] = 1'b1; // [RULE22]
            rel = 1'b1;
          end else if (pre_exp_r) begin
            rel = 1'b1; // [RULE9]
            if (CHAN_CFG[cur_ch_r].block) keep_nxt[cur_ch_r] = 1'b1; // [RULE11]
          end else begin
            rel = !eff_req[cur_ch_r];
          end
        end
      end
      default: begin
        st_nxt = ST_IDLE;
      end
    endcase
    if (rel) begin
      channel_acknowledge_n_n_nxt = 8'hFF;
      main_memory_request_n_n_nxt = 1'b1;
      owner_nxt = idp_pkg::OWN_NONE;
      pre_cnt_nxt = 6'h00;
      pre_exp_nxt = 1'b0;
      st_nxt = ST_IDLE;
    end
    swreq_nxt = swreq_nxt | SW_REQ_SET;
  end
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      st_r <= ST_IDLE;
      div_r <= 3'h0;
      bclk_en_r <= 1'b0;
      arb_rot_r <= 2'h0;
      lo_rot_r <= 2'h0;
      hi_rot_r <= 2'h0;
      cur_ch_r <= 3'h0;
      channel_acknowledge_n_n_r <= 8'hFF;
      main_memory_request_n_n_r <= 1'b1;
      owner_r <= idp_pkg::OWN_NONE;
      pre_cnt_r <= 6'h00;
      pre_exp_r <= 1'b0;
      keep_r <= 8'h00;
      swreq_r <= 8'h00;
      mask_r <= idp_pkg::MASK_RST;
      tc_r <= 8'h00;
    end else begin
      st_r <= st_nxt;
      div_r <= div_nxt;
      bclk_en_r <= bclk_nxt;
      arb_rot_r <= arb_rot_nxt;
      lo_rot_r <= lo_rot_nxt;
      hi_rot_r <= hi_rot_nxt;
      cur_ch_r <= cur_ch_nxt;
      channel_acknowledge_n_n_r <= channel_acknowledge_n_n_nxt;
      main_memory_request_n_n_r <= main_memory_request_n_n_nxt;
      owner_r <= owner_nxt;
      pre_cnt_r <= pre_cnt_nxt;
      pre_exp_r <= pre_exp_nxt;
      keep_r <= keep_nxt;
      swreq_r <= swreq_nxt;
      mask_r <= mask_nxt;
      tc_r <= tc_nxt;
    end
  end
  // -----------------------------------------------------------------
  // address and count registers
  // -----------------------------------------------------------------
  always_comb begin
    base_a_nxt = base_a_r;
    cur_a_nxt = cur_a_r;
    base_c_nxt = base_c_r;
    cur_c_nxt = cur_c_r;
    ext_nxt = ext_r;
    if (xfer_done) begin
      // compat mode wraps in the low 16 bits, pages never carry
      if (ext_cur) begin
        cur_a_nxt[cur_ch_r] = CHAN_CFG[cur_ch_r].decr ?
          cur_a_r[cur_ch_r] - 32'(step16(CHAN_CFG[cur_ch_r])) :
          cur_a_r[cur_ch_r] + 32'(step16(CHAN_CFG[cur_ch_r])); // [RULE17] [RULE19]
      end else begin
        cur_a_nxt[cur_ch_r][15:0] = CHAN_CFG[cur_ch_r].decr ?
          cur_a_r[cur_ch_r][15:0] - step16(CHAN_CFG[cur_ch_r]) :
          cur_a_r[cur_ch_r][15:0] + step16(CHAN_CFG[cur_ch_r]); // [RULE16] [RULE19]
      end
      cur_c_nxt[cur_ch_r] = cur_c_r[cur_ch_r] - 16'h0001;
      if (TERMINAL_COUNT && CHAN_CFG[cur_ch_r].autoinit) begin
        cur_a_nxt[cur_ch_r] = base_a_r[cur_ch_r]; // [RULE21]
        cur_c_nxt[cur_ch_r] = base_c_r[cur_ch_r];
      end
    end
    if (REG_WR.en) begin
      if (REG_WR.sel <= idp_pkg::SEL_HPAGE) begin
        base_a_nxt[REG_WR.ch][8*REG_WR.sel +: 8] = REG_WR.data; // [RULE21]
        cur_a_nxt[REG_WR.ch][8*REG_WR.sel +: 8] = REG_WR.data;
        ext_nxt[REG_WR.ch] = REG_WR.sel == idp_pkg::SEL_HPAGE; // [RULE16] [RULE17]
      end else if (REG_WR.sel == idp_pkg::SEL_CNT0 || REG_WR.sel == idp_pkg::SEL_CNT1) begin
        base_c_nxt[REG_WR.ch][8*REG_WR.sel[0] +: 8] = REG_WR.data;
        cur_c_nxt[REG_WR.ch][8*REG_WR.sel[0] +: 8] = REG_WR.data;
      end
    end
    for (int g = 0; g < 2; g++) begin
      if (MASTER_CLEAR[g]) ext_nxt[4*g +: 4] = 4'h0; // [RULE18]
    end
    xaddr_nxt = out_addr(cur_a_r[cur_ch_r], ext_cur, CHAN_CFG[cur_ch_r]);
    xcnt_nxt = cur_c_r[cur_ch_r];
  end
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      base_a_r <= '{default: idp_pkg::ADDR_RST};
      cur_a_r <= '{default: idp_pkg::ADDR_RST};
      base_c_r <= '{default: idp_pkg::CNT_RST};
      cur_c_r <= '{default: idp_pkg::CNT_RST};
      ext_r <= 8'h00; // [RULE18]
      xaddr_r <= idp_pkg::ADDR_RST;
      xcnt_r <= idp_pkg::CNT_RST;
    end else begin
      base_a_r <= base_a_nxt;
      cur_a_r <= cur_a_nxt;
      base_c_r <= base_c_nxt;
      cur_c_r <= cur_c_nxt;
      ext_r <= ext_nxt;
      xaddr_r <= xaddr_nxt;
      xcnt_r <= xcnt_nxt;
    end
  end
  // -----------------------------------------------------------------
  // outputs
  // -----------------------------------------------------------------
  assign CHANNEL_ACKNOWLEDGE_N = channel_acknowledge_n_n_r;
  assign MAIN_MEMORY_REQUEST_N = main_memory_request_n_n_r;
  assign BUS_OWNER = owner_r;
  assign ACTIVE_CH = cur_ch_r;
  assign XFER_ADDR = xaddr_r;
  assign XFER_COUNT = xcnt_r;
  assign TC_STATUS = tc_r;
  assign MASK_STATE = mask_r;
  assign EXT_MODE = ext_r;
  assign PREEMPT_PEND = pre_exp_r;
  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  chk_cascade_noack: assert property (channel_acknowledge_n_n_r[4] == 1'b1) // [RULE15]
    else $error("cascade channel acknowledged");
  chk_gat_main_memory_request_n: assert property (st_r == ST_MEMWAIT |-> !main_memory_request_n_n_r && &channel_acknowledge_n_n_r) // [RULE13]
    else $error("acknowledge before memory grant");
  chk_gat_grant: assert property (st_r == ST_MEMWAIT && !gnt_s && !MASTER_CLEAR[cur_ch_r[2]]
    |=> !channel_acknowledge_n_n_r[cur_ch_r] && st_r == ST_DMA) // [RULE14]
    else $error("memory grant not followed by acknowledge");
  chk_lo_rotate: assert property (xfer_done && !cur_ch_r[2] && ROTATE_LOW && MASTER_CLEAR == 2'h0
    |=> lo_rot_r == $past(cur_ch_r[1:0]) + 2'h1) // [RULE5]
    else $error("lower group did not rotate");
  chk_group_slot: assert property (xfer_done && !cur_ch_r[2] && ROTATE_HIGH && MASTER_CLEAR == 2'h0
    |=> hi_rot_r == 2'h1) // [RULE7]
    else $error("lower group slot not moved to bottom");
  chk_hi_rotate: assert property (xfer_done && cur_ch_r[2] && ROTATE_HIGH && MASTER_CLEAR == 2'h0
    |=> hi_rot_r == $past(cur_ch_r[1:0]) + 2'h1) // [RULE6]
    else $error("upper group did not rotate");
  chk_preempt_cap: assert property (pre_cnt_r <= 6'(idp_pkg::PREEMPT_BCLKS)) // [RULE9]
    else $error("preempt counter overran");
  chk_preempt_drop: assert property (xfer_done && pre_exp_r && MASTER_CLEAR == 2'h0
    |=> st_r == ST_IDLE && &channel_acknowledge_n_n_r) // [RULE9]
    else $error("preempted channel kept the bus");
  chk_compat_fixed: assert property (pre_cnt_r != 6'h00 |-> fast_cur || pre_exp_r || st_r != ST_DMA) // [RULE10]
    else $error("preempt timer ran for compatible channel");
  chk_nmi_skip: assert property (st_r == ST_IDLE && NMI_PENDING && PCI_REQ
    |=> st_r != ST_DMA && st_r != ST_MEMWAIT) // [RULE12]
    else $error("dma granted during nmi");
  chk_compat_page: assert property (!$past(ext_cur) |-> xaddr_r[31:24] == 8'h00) // [RULE16]
    else $error("high page not zero in compatibility mode");
  chk_autoinit_mask: assert property (xfer_done && TERMINAL_COUNT && !CHAN_CFG[cur_ch_r].autoinit
    |=> |(mask_r & $past(cur_bit))) // [RULE22]
    else $error("mask not set at terminal count");
endmodule

// >>> idp_mem_model.sv
// idp_mem_model: main memory arbiter beside the dma block
// assumes one clock; grant follows request after DLY+1 cycles
`timescale 1ns/1ps
module idp_mem_model #(parameter int DLY = 4) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // memory handshake
  input wire logic req_n,
  output logic grant_n
);
  int cnt;
  // the delay stands for winning pci and then main memory
  always_ff @(posedge clk or posedge rst) begin
    if (rst || req_n) begin
      cnt <= 0;
      grant_n <= 1'b1;
    end else begin
      cnt <= cnt + 1;
      grant_n <= !(cnt >= DLY);
    end
  end
endmodule

// >>> isa_dma_priority_and_address_logic_test.sv
// isa_dma_priority_and_address_logic_test: self-checking bench
// assumes the memory model answers requests; one pin request takes the full delay path
`timescale 1ns/1ps
module isa_dma_priority_and_address_logic_test;
  logic clk = 0, rst = 1, guaranteed_access_mode = 0, nmi = 0, pci = 0, done = 0, tc = 0;
  logic [7:0] pins = 8'h00, sw_req = 8'h00, mclr = 8'h00, ack_n, tcs, mask, ext;
  logic mreq_n, grant_n, pend;
  logic rfr = 0, rot_lo = 0, rot_hi = 0;
  logic [1:0] mc = 2'h0;
  logic [2:0] act;
  logic [31:0] addr;
  logic [15:0] cnt;
  idp_pkg::idp_owner_t own;
  idp_pkg::idp_chan_cfg_t [7:0] cfg = '0;
  idp_pkg::idp_wr_t wr = '0;
  int fail_count = 0, checks_done = 0, cyc = 0, r, i;
  logic [2:0] rsel [4] = '{3'h3, 3'h0, 3'h3, 3'h2};
  logic rext [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
  always #10 clk = ~clk;
  idp_dma_arb idp_dma_arb_i (.CORE_CLK(clk), .RST(rst), .CHANNEL_REQUEST_LINE(pins),
    .MAIN_MEMORY_GRANT_N(grant_n), .CHANNEL_ACKNOWLEDGE_N(ack_n),
    .MAIN_MEMORY_REQUEST_N(mreq_n), .REFRESH_REQ(rfr), .PCI_REQ(pci), .NMI_PENDING(nmi),
    .CYCLE_DONE(done), .TERMINAL_COUNT(tc), .GUARANTEED_ACCESS_MODE(guaranteed_access_mode),
    .ROTATE_LOW(rot_lo), .ROTATE_HIGH(rot_hi), .CHAN_CFG(cfg), .REG_WR(wr), .SW_REQ_SET(sw_req),
    .MASK_CLEAR(mclr), .MASTER_CLEAR(mc), .BUS_OWNER(own), .ACTIVE_CH(act),
    .XFER_ADDR(addr), .XFER_COUNT(cnt), .TC_STATUS(tcs), .MASK_STATE(mask),
    .EXT_MODE(ext), .PREEMPT_PEND(pend));
  idp_mem_model idp_mem_model_i (.clk(clk), .rst(rst), .req_n(mreq_n), .grant_n(grant_n));
  task tick;
    @(posedge clk);
    #2;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wait_own(input idp_pkg::idp_owner_t o);
    for (i = 0; i < 40 && own !== o; i++) tick();
    chk(32'(own), 32'(o));
  endtask
  task req(input logic [7:0] v);
    sw_req = v;
    tick();
    sw_req = 8'h00;
  endtask
  // last cycle with terminal count ends the grant
  task fin;
    done = 1;
    tc = 1;
    tick();
    done = 0;
    tc = 0;
    tick();
  endtask
  task end_of_test;
    if (fail_count == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc > 3000) begin
      fail_count++;
      end_of_test();
    end
  end
  initial begin
    cfg[4].cascade = 1'b1;
    repeat (20) @(posedge clk);
    #2 rst = 0;
    tick();
    chk(32'(mask), 32'hFF);
    chk(32'(ext), 32'h0);
    chk(32'(ack_n), 32'hFF);
    for (r = 0; r < 4; r++) begin
      wr = '{en: 1'b1, ch: 3'h1, sel: rsel[r], data: 8'hA5};
      tick();
      wr.en = 1'b0;
      tick();
      chk(32'(ext[1]), 32'(rext[r]));
    end
    mclr = 8'hFF;
    tick();
    mclr = 8'h00;
    req(8'h81);
    wait_own(idp_pkg::OWN_DMA);
    chk(32'(act), 32'h0);
    chk(32'(ack_n), 32'hFE);
    fin();
    chk(32'(tcs[0]), 32'h1);
    chk(32'(mask[0]), 32'h1);
    wait_own(idp_pkg::OWN_DMA);
    chk(32'(act), 32'h7);
    fin();
    cfg[2].autoinit = 1'b1;
    req(8'h04);
    wait_own(idp_pkg::OWN_DMA);
    fin();
    chk(32'(mask[2]), 32'h0);
    nmi = 1;
    pci = 1;
    req(8'h08);
    wait_own(idp_pkg::OWN_PCI);
    repeat (6) tick();
    chk(32'(own), 32'(idp_pkg::OWN_PCI));
    pci = 0;
    wait_own(idp_pkg::OWN_DMA);
    chk(32'(act), 32'h3);
    fin();
    nmi = 0;
    guaranteed_access_mode = 1;
    cfg[1].wide16 = 1'b1;
    cfg[1].shifted = 1'b1;
    req(8'h02);
    for (i = 0; i < 20 && mreq_n !== 1'b0; i++) tick();
    chk(32'(mreq_n), 32'h0);
    chk(32'(ack_n), 32'hFF);
    for (i = 0; i < 40 && ack_n === 8'hFF; i++) tick();
    chk(32'(grant_n), 32'h0);
    chk(32'(ack_n), 32'hFD);
    chk(addr, 32'h00A4014A);
    fin();
    chk(addr, 32'h00A4014C);
    chk(32'(cnt), 32'hFFFF);
    guaranteed_access_mode = 0;
    rot_lo = 1;
    rot_hi = 1;
    mclr = 8'hFF;
    req(8'h64);
    mclr = 8'h00;
    wait_own(idp_pkg::OWN_DMA);
    chk(32'(act), 32'h2);
    fin();
    chk(32'(act), 32'h5);
    req(8'h0C);
    fin();
    chk(32'(act), 32'h6);
    fin();
    chk(32'(act), 32'h3);
    fin();
    chk(32'(act), 32'h2);
    fin();
    wr = '{en: 1'b1, ch: 3'h1, sel: 3'h3, data: 8'h00};
    tick();
    wr.en = 1'b0;
    mc = 2'h1;
    tick();
    mc = 2'h0;
    chk(32'(ext[1]), 32'h0);
    chk(32'({mask[3:0], tcs[3:0]}), 32'hF0);
    cfg[5].timing = 2'h1;
    mclr = 8'h60;
    req(8'h60);
    mclr = 8'h00;
    wait_own(idp_pkg::OWN_DMA);
    repeat (185) tick();
    chk(32'(pend), 32'h0);
    repeat (7) tick();
    chk(32'(pend), 32'h1);
    done = 1;
    tick();
    done = 0;
    chk(32'(ack_n), 32'hFF);
    tick();
    chk(32'(act), 32'h6);
    fin();
    fin();
    rfr = 1;
    pci = 1;
    wait_own(idp_pkg::OWN_REF);
    rfr = 0;
    wait_own(idp_pkg::OWN_PCI);
    pci = 0;
    mclr = 8'h40;
    pins = 8'h40;
    tick();
    mclr = 8'h00;
    repeat (40) tick();
    chk(32'(own), 32'(idp_pkg::OWN_NONE));
    wait_own(idp_pkg::OWN_DMA);
    chk(32'(act), 32'h6);
    pins = 8'h00;
    fin();
    end_of_test();
  end
endmodule
